//--- hdl/sar_pkg.sv
/*
 * sar_pkg: constants, types and register map of the serial address
 * recognition receiver.
 * Assumes a single 40 MHz system clock and AHB-Lite register access.
 */
package sar_pkg;

   // clock and default bit rate
   localparam int unsigned CLK_HZ   = 40_000_000;
   localparam int unsigned BAUD_BPS = 9600;
   localparam int unsigned OVERSMP  = 16;
   // tick period is divider + 1 clocks
   localparam logic [15:0] BAUD_DIV_RST =
      16'(CLK_HZ / (BAUD_BPS * OVERSMP) - 1);
   localparam logic [15:0] M2_DIV = 16'h0001; // osc/32 bit rate

   // word indices; byte address is four times the index
   localparam logic [7:0] IDX_CTRL  = 8'h00;
   localparam logic [7:0] IDX_STAT  = 8'h01;
   localparam logic [7:0] IDX_DATA  = 8'h02;
   localparam logic [7:0] IDX_BAUD  = 8'h03;
   localparam logic [7:0] IDX_ISTAT = 8'h04;
   localparam logic [7:0] IDX_ICLR  = 8'h05;
   localparam logic [7:0] IDX_IEN   = 8'h06;
   localparam logic [7:0] IDX_SLAVE_ADDRESS = 8'hA9;
   localparam logic [7:0] IDX_SMASK = 8'hB9;

   // field positions
   localparam int CTRL_MODE  = 0;
   localparam int CTRL_REN   = 2;
   localparam int CTRL_MPE   = 3;
   localparam int CTRL_RFCLR = 4;
   localparam int STAT_RFLAG = 0;
   localparam int STAT_NINTH = 1;
   localparam int STAT_BUSY  = 2;
   localparam int EV_RX      = 0;
   localparam int EV_DROP    = 1;
   localparam int EV_FERR    = 2;
   localparam int EV_W       = 3;

   // reset values
   localparam logic [7:0] ADDR_RST = 8'h00;
   localparam logic [3:0] CTRL_RST = 4'h0;

   // sample slices and modes
   localparam logic [3:0] SLICE_A = 4'h7;
   localparam logic [3:0] SLICE_B = 4'h8;
   localparam logic [3:0] SLICE_C = 4'h9;
   localparam logic [2:0] LAST_DB = 3'h7;
   localparam logic [1:0] MODE0   = 2'h0;
   localparam logic [1:0] MODE1   = 2'h1;
   localparam logic [1:0] MODE2   = 2'h2;

   typedef struct packed {
      logic       mpe;
      logic       ren;
      logic [1:0] mode;
   } sar_ctrl_s;

   typedef struct packed {
      logic [7:0] data;
      logic       ninth;
   } sar_frame_s;

   typedef enum logic [2:0] {
      RX_IDLE  = 3'b000,
      RX_START = 3'b001,
      RX_DATA  = 3'b010,
      RX_NINTH = 3'b011,
      RX_STOP  = 3'b100
   } sar_rx_e;

endpackage

//--- hdl/sar_top.sv
/*
 * sar_top: asynchronous serial receiver with hardware slave address
 * recognition, registers on AHB-Lite, one level interrupt.
 * Assumes rxd comes from a pin (synchronised here) and one AHB slave.
 */
// Chosen here: the AHB-Lite slave port.
// Notes on behaviour
// - with multiproc_enable, flag rises only on given or broadcast match
// - with multiproc_enable, frames with ninth bit clear never set flag
// - without multiproc_enable, every complete frame sets the flag if it is clear
// - mode 1 with multiproc_enable: stop bit 1 and address match needed
// - given match compares only where mask bit is 1
// - broadcast pattern is address OR mask; its ones must match
// - address and mask registers reset to zero, so all frames match
// - frame loads only if flag clear and (no multiproc or ninth bit 1)
// - ninth bit is stored together with the data byte
`timescale 1ns/10ps
`default_nettype none
module sar_top
   import sar_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   input  wire logic        rxd,
   output logic             irq
);

   // address match on received byte against a pattern and care mask
   function automatic logic addr_hit(input logic [7:0] rx,
                                     input logic [7:0] pat,
                                     input logic [7:0] care);
      addr_hit = ((rx ^ pat) & care) == 8'h00;
   endfunction

   logic            rst_meta_q;
   logic            rst_n;
   logic            rx_meta_q;
   logic            rx_sync_q;
   logic            rx_prev_q;
   sar_ctrl_s       ctrl_q;
   logic [7:0]      slave_address_q;
   logic [7:0]      smask_q;
   logic [15:0]     baud_q;
   logic [EV_W-1:0] istat_q;
   logic [EV_W-1:0] ien_q;
   logic            rflag_q;
   sar_frame_s      rbuf_q;
   sar_rx_e         state_q;
   sar_rx_e         state_d;
   logic [15:0]     bcnt_q;
   logic [3:0]      slice_q;
   logic [1:0]      vote_q;
   logic [2:0]      nbit_q;
   logic [7:0]      shift_q;
   logic            d8_q;
   logic            wr_q;
   logic [7:0]      widx_q;
   logic [31:0]     hrdata_q;

   // reset release through two flip-flops
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rst_meta_q <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n      <= rst_meta_q;
      end
   end

   // receive pin synchroniser plus edge history
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rx_meta_q <= 1'b1;
         rx_sync_q <= 1'b1;
         rx_prev_q <= 1'b1;
      end else begin
         rx_meta_q <= rxd;
         rx_sync_q <= rx_meta_q;
         rx_prev_q <= rx_sync_q;
      end
   end

   // bus address phase decode
   wire       ahb_go  = hsel & hready & htrans[1];
   wire [7:0] a_idx   = haddr[9:2];
   wire       a_ok    = (haddr[31:10] == 22'h0) & (haddr[1:0] == 2'h0);
   wire       wr_ctrl = wr_q & (widx_q == IDX_CTRL);
   wire       wr_baud = wr_q & (widx_q == IDX_BAUD);
   wire       wr_iclr = wr_q & (widx_q == IDX_ICLR);
   wire       wr_ien  = wr_q & (widx_q == IDX_IEN);
   wire       wr_sadr = wr_q & (widx_q == IDX_SLAVE_ADDRESS);
   wire       wr_smsk = wr_q & (widx_q == IDX_SMASK);
   wire       rf_clr  = wr_ctrl & hwdata[CTRL_RFCLR];

   // read selection, unmapped words read as zero
   wire [31:0] rd_mux =
      !a_ok                ? 32'h0 :
      (a_idx == IDX_CTRL)  ? {28'h0, ctrl_q} :
      (a_idx == IDX_STAT)  ? {29'h0, (state_q != RX_IDLE),
                              rbuf_q.ninth, rflag_q} :
      (a_idx == IDX_DATA)  ? {24'h0, rbuf_q.data} :
      (a_idx == IDX_BAUD)  ? {16'h0, baud_q} :
      (a_idx == IDX_ISTAT) ? {29'h0, istat_q} :
      (a_idx == IDX_IEN)   ? {29'h0, ien_q} :
      (a_idx == IDX_SLAVE_ADDRESS) ? {24'h0, slave_address_q} :
      (a_idx == IDX_SMASK) ? {24'h0, smask_q} : 32'h0;

   // bus phase registers; zero wait, read data captured at address phase
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wr_q     <= 1'b0;
         widx_q   <= 8'h00;
         hrdata_q <= 32'h0;
      end else begin
         wr_q   <= ahb_go & hwrite & a_ok;
         widx_q <= a_idx;
         if (ahb_go & !hwrite) begin
            hrdata_q <= rd_mux;
         end
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_q;

   // software registers; address and mask clear to zero
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q  <= CTRL_RST;
         slave_address_q <= ADDR_RST;
         smask_q <= ADDR_RST;
         baud_q  <= BAUD_DIV_RST;
         ien_q   <= '0;
      end else begin
         if (wr_ctrl) begin
            ctrl_q <= hwdata[CTRL_MPE:CTRL_MODE];
         end
         if (wr_sadr) begin
            slave_address_q <= hwdata[7:0];
         end
         if (wr_smsk) begin
            smask_q <= hwdata[7:0];
         end
         if (wr_baud) begin
            baud_q <= hwdata[15:0];
         end
         if (wr_ien) begin
            ien_q <= hwdata[EV_W-1:0];
         end
      end
   end

   // oversampling tick; mode 2 runs at a fixed fraction of the clock
   wire [15:0] div_sel = (ctrl_q.mode == MODE2) ? M2_DIV : baud_q;
   wire        tick    = (bcnt_q >= div_sel);
   wire        rx_fall = rx_prev_q & ~rx_sync_q;
   wire        start   = (state_q == RX_IDLE) & rx_fall & ctrl_q.ren &
                         (ctrl_q.mode != MODE0);
   wire        vbit    = (vote_q[0] & vote_q[1]) |
                         (vote_q[0] & rx_sync_q) |
                         (vote_q[1] & rx_sync_q);
   wire        bit_evt = tick & (slice_q == SLICE_C);

   // frame decision: compare finishes on the shifted byte first
   wire        done    = bit_evt & (state_q == RX_STOP);
   wire        ninth   = (ctrl_q.mode == MODE1) ? vbit : d8_q;
   wire [7:0]  bcast   = slave_address_q | smask_q;
   wire        m_given = addr_hit(shift_q, slave_address_q, smask_q);
   wire        m_bcast = addr_hit(shift_q, bcast, bcast);
   wire        match   = m_given | m_bcast;
   wire        mp_ok   = !ctrl_q.mpe | (ninth & match);
   wire        accept  = done & !rflag_q & mp_ok;
   wire [EV_W-1:0] ev  = {done & !vbit,
                          done & rflag_q & mp_ok,
                          accept};

   // receiver sequence, stepping at the middle of each bit
   always_comb begin
      state_d = state_q;
      case (state_q)
         RX_IDLE: begin
            if (start) begin
               state_d = RX_START;
            end
         end
         RX_START: begin
            if (bit_evt) begin
               state_d = vbit ? RX_IDLE : RX_DATA;
            end
         end
         RX_DATA: begin
            if (bit_evt && nbit_q == LAST_DB) begin
               state_d = (ctrl_q.mode == MODE1) ? RX_STOP : RX_NINTH;
            end
         end
         RX_NINTH: begin
            if (bit_evt) begin
               state_d = RX_STOP;
            end
         end
         RX_STOP: begin
            if (bit_evt) begin
               state_d = RX_IDLE;
            end
         end
         default: state_d = RX_IDLE;
      endcase
   end

   // bit timing counters and vote samples
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         bcnt_q  <= 16'h0;
         slice_q <= 4'h0;
         vote_q  <= 2'h3;
      end else begin
         bcnt_q <= (tick | start) ? 16'h0 : bcnt_q + 16'h1;
         if (start) begin
            slice_q <= 4'h0;
         end else if (tick) begin
            slice_q <= slice_q + 4'h1;
         end
         if (tick & (slice_q == SLICE_A)) begin
            vote_q[0] <= rx_sync_q;
         end
         if (tick & (slice_q == SLICE_B)) begin
            vote_q[1] <= rx_sync_q;
         end
      end
   end

   // state, data shift (lsb first) and ninth bit capture
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= RX_IDLE;
         nbit_q  <= 3'h0;
         shift_q <= 8'h00;
         d8_q    <= 1'b0;
      end else begin
         state_q <= state_d;
         if (start) begin
            nbit_q <= 3'h0;
         end else if (bit_evt & (state_q == RX_DATA)) begin
            shift_q <= {vbit, shift_q[7:1]};
            nbit_q  <= nbit_q + 3'h1;
         end
         if (bit_evt & (state_q == RX_NINTH)) begin
            d8_q <= vbit;
         end
      end
   end

   // receive buffer, flag (set wins over clear) and event flags
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rflag_q <= 1'b0;
         rbuf_q  <= '0;
         istat_q <= '0;
      end else begin
         rflag_q <= accept | (rflag_q & !rf_clr);
         if (accept) begin
            rbuf_q <= '{data: shift_q, ninth: ninth};
         end
         istat_q <= ev | (istat_q & ~(wr_iclr ? hwdata[EV_W-1:0] : '0));
      end
   end

   assign irq = |(istat_q & ien_q);

   // checks
   property p_mp_data;
      @(posedge clk_sys) disable iff (!rst_n)
      done && ctrl_q.mpe && !ninth |=> !$rose(rflag_q);
   endproperty
   a_mp_data: assert property (p_mp_data)
      else $error("data frame set flag in multiproc mode");

   property p_mp_miss;
      @(posedge clk_sys) disable iff (!rst_n)
      done && ctrl_q.mpe && ninth && !m_given && !m_bcast
      |=> !$rose(rflag_q) && $stable(rbuf_q);
   endproperty
   a_mp_miss: assert property (p_mp_miss)
      else $error("unmatched address frame was taken");

   property p_plain;
      @(posedge clk_sys) disable iff (!rst_n)
      done && !ctrl_q.mpe && !rflag_q
      |=> rflag_q && rbuf_q.data == $past(shift_q);
   endproperty
   a_plain: assert property (p_plain)
      else $error("frame not taken with multiproc off");

   property p_m1_stop;
      @(posedge clk_sys) disable iff (!rst_n)
      done && ctrl_q.mode == MODE1 && ctrl_q.mpe && !vbit
      |=> !$rose(rflag_q);
   endproperty
   a_m1_stop: assert property (p_m1_stop)
      else $error("mode 1 frame with bad stop taken");

   property p_given;
      @(posedge clk_sys) disable iff (!rst_n)
      done && ctrl_q.mpe && ninth && !rflag_q &&
      ((shift_q & smask_q) == (slave_address_q & smask_q)) |=> rflag_q;
   endproperty
   a_given: assert property (p_given)
      else $error("masked given address not recognised");

   property p_bcast;
      @(posedge clk_sys) disable iff (!rst_n)
      done && ctrl_q.mpe && ninth && !rflag_q &&
      ((shift_q | slave_address_q | smask_q) == shift_q) |=> rflag_q;
   endproperty
   a_bcast: assert property (p_bcast)
      else $error("broadcast address not recognised");

   property p_rst_addr;
      @(posedge clk_sys) $rose(rst_n) |-> slave_address_q == 8'h00 &&
         smask_q == 8'h00;
   endproperty
   a_rst_addr: assert property (p_rst_addr)
      else $error("address registers not zero after reset");

   property p_busy_flag;
      @(posedge clk_sys) disable iff (!rst_n)
      done && rflag_q |=> $stable(rbuf_q) ##1 $stable(rbuf_q) || accept;
   endproperty
   a_busy_flag: assert property (p_busy_flag)
      else $error("buffer overwritten while flag set");

   property p_ninth;
      @(posedge clk_sys) disable iff (!rst_n)
      accept |=> rbuf_q.ninth == $past(ninth) && rflag_q;
   endproperty
   a_ninth: assert property (p_ninth)
      else $error("ninth bit not stored with byte");

   property p_rise_cause;
      @(posedge clk_sys) disable iff (!rst_n)
      $rose(rflag_q) |-> $past(done) && $past(mp_ok);
   endproperty
   a_rise_cause: assert property (p_rise_cause)
      else $error("flag rose without a completed frame");

   c_mp_take: cover property (@(posedge clk_sys) accept && ctrl_q.mpe);
   c_bc_only: cover property (@(posedge clk_sys)
      accept && ctrl_q.mpe && m_bcast && !m_given);
   c_drop: cover property (@(posedge clk_sys) ev[EV_DROP]);
   c_ferr: cover property (@(posedge clk_sys) ev[EV_FERR] ##[1:50] irq);

endmodule // sar_top
`default_nettype wire

//--- tb/sar_remote_master.sv
/*
 * sar_remote_master: far-side serial transmitter that drives rxd.
 * Assumes bit_clk matches the receiver's bit period in clocks.
 */
`timescale 1ns/10ps
`default_nettype none
module sar_remote_master (
   input  wire logic clk_sys,
   output var logic  rxd
);
   int unsigned bit_clk = 32;

   // line idles high, as with a pull-up
   initial rxd = 1'b1;

   // start, data lsb first, ninth or stop bit, stop, then an idle bit
   task automatic send(input logic [7:0] d, input logic b9,
                       input logic nine);
      logic [11:0] f;
      f = {2'b11, b9, d, 1'b0};
      for (int i = 0; i < (nine ? 12 : 11); i++) begin
         @(posedge clk_sys);
         rxd <= f[i];
         repeat (bit_clk - 1) @(posedge clk_sys);
      end
   endtask
endmodule // sar_remote_master
`default_nettype wire

//--- tb/sar_top_tb_top.sv
/*
 * sar_top_tb_top: self-checking bench for the address recognition
 * receiver. Assumes one AHB slave and the remote master model on rxd.
 */
`timescale 1ns/10ps
`default_nettype none
module sar_top_tb_top
   import sar_pkg::*;
;
   logic        clk_sys = 1'b0;
   logic        rstn, hsel, hwrite, rd_ph, hreadyout, hresp, irq, rxd;
   logic [31:0] haddr, hwdata, hrdata, ctl, rs, r;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [7:0]  sa, mk, ld;
   logic        mpe, nb, ien;
   int          err_count, samples_checked;
   logic [31:0] exp_q[$];
   string       nm_q[$];
   wire         hready = hreadyout;

   sar_top uut (.clk_sys(clk_sys), .rstn(rstn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .rxd(rxd), .irq(irq));
   sar_remote_master tx (.clk_sys(clk_sys), .rxd(rxd));

   // 40 MHz clock
   always #12.5 clk_sys = ~clk_sys;

   task automatic tally_and_finish();
      $display("compared %0d mismatched %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] s,
                      input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask

   // one single word transfer, waiting on hready in both phases
   task automatic bus(input logic w, input logic [7:0] idx,
                      input logic [31:0] d);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr  <= {22'h0, idx, 2'b00};
      do @(posedge clk_sys); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      rd_ph  <= !w;
      do @(posedge clk_sys); while (hready !== 1'b1);
      rd_ph  <= 1'b0;
   endtask

   // read that notes its expected word for the monitor
   task automatic rd(input string nm, input logic [7:0] idx,
                     input logic [31:0] e);
      exp_q.push_back(e);
      nm_q.push_back(nm);
      bus(1'b0, idx, 32'h0);
   endtask

   // monitor: read data is taken at the edge that ends the data phase
   always @(posedge clk_sys)
      if (rd_ph === 1'b1 && hready === 1'b1) begin
         chk(nm_q.pop_front(), hrdata, exp_q.pop_front());
         chk("hresp", {31'h0, hresp}, 32'h0); // slave always answers OKAY
      end

   function automatic logic [31:0] xs();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction

   // expected acceptance from given and broadcast address matching
   function automatic logic acc(input logic [7:0] a, input logic b9);
      logic [7:0] bc;
      bc = sa | mk;
      return !mpe || (b9 && (((a ^ sa) & mk) == 8'h00 || (a & bc) == bc));
   endfunction

   task automatic set_ctl(input logic [1:0] md, input logic m);
      mpe = m;
      ctl = {28'h0, m, 1'b1, md};
      bus(1'b1, IDX_CTRL, ctl);
      rd("ctrl", IDX_CTRL, ctl);
   endtask

   // send a frame, check flag, ninth bit, byte, events and irq, clear
   task automatic frame(input logic [7:0] d, input logic b9,
                        input logic nine);
      logic a;
      a = acc(d, b9);
      tx.send(d, b9, nine);
      if (a) begin
         nb = b9;
         ld = d;
      end
      rd("stat", IDX_STAT, {29'h0, 1'b0, nb, a});
      rd("data", IDX_DATA, {24'h0, ld});
      rd("istat", IDX_ISTAT, {29'h0, !nine && !b9, 1'b0, a});
      chk("irq", {31'h0, irq}, {31'h0, a & ien});
      bus(1'b1, IDX_ICLR, 32'h7);
      bus(1'b1, IDX_CTRL, ctl | (32'h1 << CTRL_RFCLR));
   endtask

   // watchdog sized well past the expected run length
   initial begin
      repeat (80000) @(posedge clk_sys);
      err_count++;
      tally_and_finish();
   end

   initial begin
      logic [7:0] tbl[7] = '{8'hA0, 8'hA3, 8'hA5, 8'hAC, 8'hFF,
                             8'hFE, 8'h7E};
      rstn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00;
      hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0; rd_ph = 1'b0;
      rs = 32'h8; sa = 8'h00; mk = 8'h00; ld = 8'h00; nb = 1'b0;
      ien = 1'b1;
      repeat (12) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (4) @(posedge clk_sys);
      rd("slave_address", IDX_SLAVE_ADDRESS, 32'h0);
      rd("smask", IDX_SMASK, 32'h0);
      rd("ctrl", IDX_CTRL, 32'h0);
      rd("baud", IDX_BAUD, 32'h103);
      rd("ien", IDX_IEN, 32'h0);
      rd("unmapped", 8'h07, 32'h0);
      bus(1'b1, IDX_BAUD, 32'h1);
      bus(1'b1, IDX_IEN, 32'h1);
      set_ctl(MODE2 | MODE1, 1'b1);
      frame(8'h5A, 1'b1, 1'b1);
      frame(8'h5A, 1'b0, 1'b1);
      sa = 8'hA4;
      mk = 8'hFA;
      bus(1'b1, IDX_SLAVE_ADDRESS, {24'h0, sa});
      bus(1'b1, IDX_SMASK, {24'h0, mk});
      rd("slave_address", IDX_SLAVE_ADDRESS, 32'hA4);
      rd("smask", IDX_SMASK, 32'hFA);
      foreach (tbl[i]) frame(tbl[i], 1'b1, 1'b1);
      frame(8'hA0, 1'b0, 1'b1);
      for (int i = 0; i < 6; i++) begin
         r = xs();
         frame(r[7:0], 1'b1, 1'b1);
      end
      set_ctl(MODE1, 1'b1);
      frame(8'hA0, 1'b1, 1'b0);
      frame(8'hA0, 1'b0, 1'b0);
      frame(8'h33, 1'b1, 1'b0);
      // fixed rate mode, then a data frame watched while it is received
      set_ctl(MODE2, 1'b1);
      frame(8'hFE, 1'b1, 1'b1);
      frame(8'hA1, 1'b1, 1'b1);
      fork
         tx.send(8'hA0, 1'b0, 1'b1);
         begin
            repeat (100) @(posedge clk_sys);
            rd("busy", IDX_STAT, {29'h0, 1'b1, nb, 1'b0});
         end
      join
      rd("stat", IDX_STAT, {29'h0, 1'b0, nb, 1'b0});
      // mode 0 receiver stays idle: no flag, no events
      set_ctl(MODE0, 1'b0);
      tx.send(8'h44, 1'b1, 1'b1);
      rd("stat", IDX_STAT, {29'h0, 1'b0, nb, 1'b0});
      rd("istat", IDX_ISTAT, 32'h0);
      set_ctl(MODE2 | MODE1, 1'b0);
      bus(1'b1, IDX_IEN, 32'h0);
      ien = 1'b0;
      frame(8'h33, 1'b0, 1'b1);
      r = xs();
      frame(r[7:0], r[8], 1'b1);
      tx.send(8'h11, 1'b1, 1'b1);
      tx.send(8'h22, 1'b0, 1'b1);
      rd("data", IDX_DATA, 32'h11);
      rd("stat", IDX_STAT, 32'h3);
      rd("istat", IDX_ISTAT, 32'h3);
      repeat (2) @(posedge clk_sys);
      tally_and_finish();
   end
endmodule // sar_top_tb_top
`default_nettype wire
